// >>> adc_conversion_setup.sv
// conversion settings registers and conversion sequencer
//
// The implementer's own choices: strobed register access and the register offsets.
module adc_conversion_setup (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [15:0] rdata,
	input wire logic [15:0] converter_result,
	output logic converter_clock,
	output logic conv_busy,
	output logic conv_done,
	output adc_setup_pkg::conv_setup_s active_setup
);
	typedef struct packed {
		logic [2:0][15:0] word_a;
		logic [2:0][15:0] word_b;
		logic [2:0][15:0] result;
		adc_setup_pkg::phase_e phase;
		logic busy;
		logic [1:0] chan;
		logic [11:0] count;
		logic done;
		logic err;
		logic done_pulse;
		logic tick_q;
		adc_setup_pkg::conv_setup_s setup;
		logic [15:0] rdata;
		logic [15:0] sync1;
		logic [15:0] sync2;
	} top_state_s;

	top_state_s st_reg;
	top_state_s st_next;
	logic conv_tick;
	logic [1:0] sel;
	adc_setup_pkg::conv_setup_s pick;

	conv_clock_divider u_div (
		.clk(clk),
		.rstn(rstn),
		.run(st_reg.phase == adc_setup_pkg::CONVERTING),
		.conv_clock_select(st_reg.setup.conv_clock_select),
		.conv_tick(conv_tick)
	);

	// per-channel decode of the two setup words
	generate
		for (genvar ch = 0; ch < 3; ch++) begin : g_chan
			adc_setup_pkg::conv_setup_s decoded;
			always_comb begin
				decoded.gain_code = st_reg.word_a[ch][adc_setup_pkg::GAIN_LSB +: 5];
				decoded.conv_clock_select = st_reg.word_a[ch][adc_setup_pkg::CLOCK_LSB +: 3];
				decoded.resolution_select = st_reg.word_a[ch][adc_setup_pkg::RES_LSB +: 3];
				decoded.coarse_offset_code = st_reg.word_a[ch][adc_setup_pkg::OFFSET_LSB +: 4];
				decoded.bias_level_select = st_reg.word_b[ch][adc_setup_pkg::BIAS_LSB +: 3];
				decoded.reference_select = st_reg.word_b[ch][adc_setup_pkg::REF_LSB +: 2];
				// temperature channel has no gain or reference choice
				if (ch == 2) begin
					decoded.gain_code = 5'h00;
					decoded.reference_select = adc_setup_pkg::REF_SUPPLY;
				end
				decoded.offset_band = adc_setup_pkg::offset_band(decoded.gain_code);
			end
		end
	endgenerate

	always_comb begin
		st_next = st_reg;
		st_next.done_pulse = 1'b0;
		st_next.tick_q = conv_tick;
		st_next.rdata = 16'h0000;
		// analog side is asynchronous; second stage is the only reader
		st_next.sync1 = converter_result;
		st_next.sync2 = st_reg.sync1;
		sel = 2'(wdata[1:0] - 2'h1);
		// explicit choice keeps code 0 from indexing past the last channel
		if (wdata[1:0] == 2'h2) begin
			pick = g_chan[1].decoded;
		end else if (wdata[1:0] == 2'h3) begin
			pick = g_chan[2].decoded;
		end else begin
			pick = g_chan[0].decoded;
		end

		if (wr_stb) begin
			if (addr == adc_setup_pkg::CH1_WORD_A_OFFSET) begin
				st_next.word_a[0] = wdata & adc_setup_pkg::SENSOR_A_MASK;
			end else if (addr == adc_setup_pkg::CH1_WORD_B_OFFSET) begin
				st_next.word_b[0] = wdata & adc_setup_pkg::SENSOR_B_MASK;
			end else if (addr == adc_setup_pkg::CH2_WORD_A_OFFSET) begin
				st_next.word_a[1] = wdata & adc_setup_pkg::SENSOR_A_MASK;
			end else if (addr == adc_setup_pkg::CH2_WORD_B_OFFSET) begin
				st_next.word_b[1] = wdata & adc_setup_pkg::SENSOR_B_MASK;
			end else if (addr == adc_setup_pkg::TMP_WORD_A_OFFSET) begin
				st_next.word_a[2] = wdata & adc_setup_pkg::TMP_A_MASK;
			end else if (addr == adc_setup_pkg::TMP_WORD_B_OFFSET) begin
				st_next.word_b[2] = wdata & adc_setup_pkg::TMP_B_MASK;
			end else if (addr == adc_setup_pkg::CONTROL_OFFSET) begin
				// start ignored while busy or with channel code 0
				if (st_reg.phase == adc_setup_pkg::IDLE && wdata[1:0] != 2'h0) begin
					st_next.chan = sel;
					st_next.done = 1'b0;
					st_next.setup = pick;
					if (pick.resolution_select == adc_setup_pkg::RES_RESERVED) begin
						st_next.err = 1'b1;
					end else begin
						st_next.err = 1'b0;
						st_next.count = 12'h000;
						st_next.phase = adc_setup_pkg::CONVERTING;
					end
				end
			end
		end

		case (st_reg.phase)
			adc_setup_pkg::IDLE: begin
			end
			adc_setup_pkg::CONVERTING: begin
				// length in converter clocks, each one divisor master clocks long
				if (conv_tick) begin
					if (st_reg.count == 12'(adc_setup_pkg::conv_length(st_reg.setup.resolution_select) - 12'h001)) begin
						st_next.phase = adc_setup_pkg::IDLE;
						st_next.done = 1'b1;
						st_next.done_pulse = 1'b1;
						st_next.result[st_reg.chan] = st_reg.sync2 & adc_setup_pkg::result_mask(st_reg.setup.resolution_select);
					end else begin
						st_next.count = st_reg.count + 12'h001;
					end
				end
			end
			default: begin
				st_next.phase = adc_setup_pkg::IDLE;
			end
		endcase
		st_next.busy = (st_next.phase == adc_setup_pkg::CONVERTING);

		if (rd_stb) begin
			if (addr == adc_setup_pkg::CH1_WORD_A_OFFSET) begin
				st_next.rdata = st_reg.word_a[0];
			end else if (addr == adc_setup_pkg::CH1_WORD_B_OFFSET) begin
				st_next.rdata = st_reg.word_b[0];
			end else if (addr == adc_setup_pkg::CH2_WORD_A_OFFSET) begin
				st_next.rdata = st_reg.word_a[1];
			end else if (addr == adc_setup_pkg::CH2_WORD_B_OFFSET) begin
				st_next.rdata = st_reg.word_b[1];
			end else if (addr == adc_setup_pkg::TMP_WORD_A_OFFSET) begin
				st_next.rdata = st_reg.word_a[2];
			end else if (addr == adc_setup_pkg::TMP_WORD_B_OFFSET) begin
				st_next.rdata = st_reg.word_b[2];
			end else if (addr == adc_setup_pkg::STATUS_OFFSET) begin
				st_next.rdata[adc_setup_pkg::STATUS_BUSY_BIT] = (st_reg.phase == adc_setup_pkg::CONVERTING);
				st_next.rdata[adc_setup_pkg::STATUS_DONE_BIT] = st_reg.done;
				st_next.rdata[adc_setup_pkg::STATUS_ERR_BIT] = st_reg.err;
				st_next.rdata[adc_setup_pkg::STATUS_CHAN_LSB +: 2] = st_reg.chan;
			end else if (addr == adc_setup_pkg::DATA1_OFFSET) begin
				st_next.rdata = st_reg.result[0];
			end else if (addr == adc_setup_pkg::DATA2_OFFSET) begin
				st_next.rdata = st_reg.result[1];
			end else if (addr == adc_setup_pkg::DATAT_OFFSET) begin
				st_next.rdata = st_reg.result[2];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_reg <= '0;
			st_reg.phase <= adc_setup_pkg::IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata = st_reg.rdata;
	assign converter_clock = st_reg.tick_q;
	assign conv_busy = st_reg.busy;
	assign conv_done = st_reg.done_pulse;
	assign active_setup = st_reg.setup;
endmodule : adc_conversion_setup

// >>> adc_setup_pkg.sv
// constants, types and lookups shared by the conversion sequencer
package adc_setup_pkg;
	localparam int SYS_CLOCK_FREQ_HZ = 20_000_000;
	localparam int MASTER_CLOCK_FREQ_HZ = 4_000_000;
	localparam int MASTER_TICK_CYCLES = SYS_CLOCK_FREQ_HZ / MASTER_CLOCK_FREQ_HZ;
	localparam int BASE_DIVISOR = 4;
	localparam logic [7:0] CH1_WORD_A_OFFSET = 8'h02;
	localparam logic [7:0] CH1_WORD_B_OFFSET = 8'h03;
	localparam logic [7:0] CH2_WORD_A_OFFSET = 8'h05;
	localparam logic [7:0] CH2_WORD_B_OFFSET = 8'h06;
	localparam logic [7:0] TMP_WORD_A_OFFSET = 8'h08;
	localparam logic [7:0] TMP_WORD_B_OFFSET = 8'h09;
	localparam logic [7:0] CONTROL_OFFSET = 8'h20;
	localparam logic [7:0] STATUS_OFFSET = 8'h21;
	localparam logic [7:0] DATA1_OFFSET = 8'h22;
	localparam logic [7:0] DATA2_OFFSET = 8'h23;
	localparam logic [7:0] DATAT_OFFSET = 8'h24;
	localparam int GAIN_LSB = 11;
	localparam int CLOCK_LSB = 8;
	localparam int RES_LSB = 4;
	localparam int OFFSET_LSB = 0;
	localparam int BIAS_LSB = 4;
	localparam int REF_LSB = 0;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;
	localparam int STATUS_ERR_BIT = 2;
	localparam int STATUS_CHAN_LSB = 4;
	localparam logic [15:0] SENSOR_A_MASK = 16'hFF7F;
	localparam logic [15:0] SENSOR_B_MASK = 16'h0073;
	localparam logic [15:0] TMP_A_MASK = 16'h077F;
	localparam logic [15:0] TMP_B_MASK = 16'h0070;
	localparam logic [15:0] CONFIG_RESET = 16'h0000;
	localparam logic [2:0] RES_RESERVED = 3'h7;
	localparam logic [1:0] REF_SUPPLY = 2'h0;

	typedef enum logic [1:0] {IDLE, CONVERTING} phase_e;

	typedef struct packed {
		logic [4:0] gain_code;
		logic [2:0] conv_clock_select;
		logic [2:0] resolution_select;
		logic [3:0] coarse_offset_code;
		logic [1:0] offset_band;
		logic [2:0] bias_level_select;
		logic [1:0] reference_select;
	} conv_setup_s;

	function automatic logic [11:0] conv_length(input logic [2:0] res);
		case (res)
			3'h0: conv_length = 12'd256;
			3'h1: conv_length = 12'd320;
			3'h2: conv_length = 12'd512;
			3'h3: conv_length = 12'd640;
			3'h4: conv_length = 12'd800;
			3'h5: conv_length = 12'd1280;
			default: conv_length = 12'd2048;
		endcase
	endfunction : conv_length

	// 9,10,12,13,14,15,16 bits
	function automatic logic [15:0] result_mask(input logic [2:0] res);
		case (res)
			3'h0: result_mask = 16'h01FF;
			3'h1: result_mask = 16'h03FF;
			3'h2: result_mask = 16'h0FFF;
			3'h3: result_mask = 16'h1FFF;
			3'h4: result_mask = 16'h3FFF;
			3'h5: result_mask = 16'h7FFF;
			default: result_mask = 16'hFFFF;
		endcase
	endfunction : result_mask

	// unlisted gain codes fall into the band above them
	function automatic logic [1:0] offset_band(input logic [4:0] gain);
		if (gain <= 5'h08) begin
			offset_band = 2'h0;
		end else if (gain <= 5'h10) begin
			offset_band = 2'h1;
		end else begin
			offset_band = 2'h2;
		end
	endfunction : offset_band
endpackage : adc_setup_pkg

// >>> conv_clock_divider.sv
// master clock enable and selectable converter clock enable
module conv_clock_divider (
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic [2:0] conv_clock_select,
	output logic conv_tick
);
	typedef struct packed {
		logic [2:0] pre;
		logic [8:0] div;
		logic tick;
	} div_state_s;

	div_state_s st_reg;
	div_state_s st_next;
	logic master_tick;
	logic [8:0] div_last;

	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		master_tick = (st_reg.pre == 3'(adc_setup_pkg::MASTER_TICK_CYCLES - 1));
		div_last = 9'((adc_setup_pkg::BASE_DIVISOR << conv_clock_select) - 1);
		st_next.pre = master_tick ? 3'h0 : st_reg.pre + 3'h1;
		if (!run) begin
			// restart the count so every conversion waits a full divisor of master ticks for its first tick
			st_next.div = 9'h000;
		end else if (master_tick) begin
			if (st_reg.div == div_last) begin
				st_next.div = 9'h000;
				st_next.tick = 1'b1;
			end else begin
				st_next.div = st_reg.div + 9'h001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign conv_tick = st_reg.tick;
endmodule : conv_clock_divider

// >>> adc_conversion_setup_props.sv
// port-level checker for the conversion sequencer
module adc_conversion_setup_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [15:0] rdata,
	input wire logic [15:0] converter_result,
	input wire logic converter_clock,
	input wire logic conv_busy,
	input wire logic conv_done,
	input wire adc_setup_pkg::conv_setup_s active_setup
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_RD_SLOT: assert property (!$past(rd_stb) |-> rdata == 16'h0000) else $error("rdata out of slot");
	AST_DONE_END: assert property (conv_done |-> $past(conv_busy) && !conv_busy) else $error("done not at end");
	AST_DONE_ONE: assert property (conv_done |=> !conv_done) else $error("done too long");
	AST_SETUP_HOLD: assert property (conv_busy && $past(conv_busy) |-> $stable(active_setup)) else $error("setup moved");
	AST_TICK_BUSY: assert property (converter_clock |-> $past(conv_busy)) else $error("tick while idle");
	AST_TICK_GAP: assert property (converter_clock |=> !converter_clock [*8]) else $error("ticks too close");
	AST_BUSY_MIN: assert property ($rose(conv_busy) |-> conv_busy [*8]) else $error("conversion too short");
	AST_BAND: assert property (conv_busy |-> active_setup.offset_band == (active_setup.gain_code <= 5'h08 ? 2'h0 :
		(active_setup.gain_code <= 5'h10 ? 2'h1 : 2'h2))) else $error("wrong offset band");
	cover property ($rose(conv_busy));
	cover property (converter_clock);
	cover property (conv_done);
endmodule : adc_conversion_setup_chk

bind adc_conversion_setup adc_conversion_setup_chk chk (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
	.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .converter_result(converter_result),
	.converter_clock(converter_clock), .conv_busy(conv_busy), .conv_done(conv_done), .active_setup(active_setup));

// >>> adc_front_model.sv
// behavioural analog converter front end
module adc_front_model (
	input wire logic clk,
	input wire logic conv_busy,
	output logic [15:0] converter_result
);
	timeunit 1ns;
	timeprecision 1ns;
	initial converter_result = 16'h0000;
	// toggles when idle so a late sample cannot pass
	always @(posedge clk) converter_result <= conv_busy ? 16'hA5C3 : ~converter_result;
endmodule : adc_front_model

// >>> adc_conversion_setup_tb.sv
// self-checking bench for the conversion sequencer
module adc_conversion_setup_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [15:0] rdata;
	logic [15:0] converter_result;
	logic converter_clock;
	logic conv_busy;
	logic conv_done;
	adc_setup_pkg::conv_setup_s active_setup;
	int error_cnt = 0;
	int cmp_count = 0;
	logic [15:0] rd_val;
	logic [7:0] ra [6] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09};
	logic [15:0] rm [6] = '{16'hFF7F, 16'h0073, 16'hFF7F, 16'h0073, 16'h077F, 16'h0070};
	initial forever #25 clk = ~clk;
	adc_conversion_setup dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .converter_result(converter_result), .converter_clock(converter_clock),
		.conv_busy(conv_busy), .conv_done(conv_done), .active_setup(active_setup));
	adc_front_model fe (.clk(clk), .conv_busy(conv_busy), .converter_result(converter_result));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task wrap_up;
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 rd_val = rdata;
	endtask : rd
	// a second start mid-run must be ignored
	task conv(input logic [15:0] ch, input int len, input int dv, input logic [31:0] setup);
		int n;
		int t;
		int f;
		n = 0;
		t = 0;
		f = 0;
		wr(8'h20, ch);
		do begin
			@(posedge clk);
			wr_stb <= (n == 100);
			#1;
			n++;
			t += converter_clock;
			if (f == 0 && converter_clock === 1'b1) begin
				f = n;
			end
		end while (conv_done !== 1'b1 && n < 60000);
		check(f >= dv * 5 - 3 && f <= dv * 5 + 1, 1);
		check(n - f, len * dv * 5 - dv * 5);
		check(t, len);
		check(active_setup, setup);
	endtask : conv
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rd(8'h07);
		check(rd_val, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			wr(ra[i], 16'hFFFF);
			rd(ra[i]);
			check(rd_val, rm[i]);
		end
		wr(8'h02, 16'h480A);
		wr(8'h03, 16'h0062);
		conv(16'h0001, 256, 4, {10'h0, 5'h09, 3'h0, 3'h0, 4'hA, 2'h1, 3'h6, 2'h2});
		rd(8'h22);
		check(rd_val, 16'h01C3);
		rd(8'h21);
		check(rd_val, 16'h0002);
		wr(8'h05, 16'hA01F);
		wr(8'h06, 16'h0071);
		conv(16'h0002, 320, 4, {10'h0, 5'h14, 3'h0, 3'h1, 4'hF, 2'h2, 3'h7, 2'h1});
		rd(8'h23);
		check(rd_val, 16'h01C3);
		wr(8'h08, 16'hF105);
		wr(8'h09, 16'h0070);
		conv(16'h0003, 256, 8, {10'h0, 5'h00, 3'h1, 3'h0, 4'h5, 2'h0, 3'h7, 2'h0});
		rd(8'h21);
		check(rd_val, 16'h0022);
		wr(8'h20, 16'h0000);
		rd(8'h21);
		check(rd_val, 16'h0022);
		wr(8'h02, 16'h0070);
		wr(8'h20, 16'h0001);
		repeat (3) @(posedge clk);
		#1 check(conv_busy, 1'b0);
		rd(8'h21);
		check(rd_val, 16'h0004);
		wrap_up();
	end
	initial begin
		#2000000;
		error_cnt++;
		wrap_up();
	end
endmodule : adc_conversion_setup_tb
